//--- hbm_top.sv
// Half-bridge motor control: registers, chopping, protection and output gating
`timescale 1ns/10ps
`include "hbm_map.svh"

module hbm_top
    import hbm_pkg::*;
#(
    parameter int LEGS = 4
)(
    input  wire logic            clk_i,
    input  wire logic            reset_n_i,
    input  wire logic [3:0]      reg_addr_i,
    input  wire logic            reg_wr_en_i,
    input  wire logic            reg_rd_en_i,
    input  wire logic [7:0]      reg_wdata_i,
    output logic      [7:0]      reg_rdata_o,
    input  wire logic            chop_clock_in_i,
    input  wire logic [LEGS-1:0] ls_limit_hit_i,
    input  wire logic            hs_overcurrent_i,
    input  wire logic            ls_overcurrent_i,
    input  wire logic [LEGS-1:0] hs_gate_off_i,
    input  wire logic [LEGS-1:0] ls_gate_off_i,
    input  wire logic [LEGS-1:0] recirc_detect_i,
    input  wire logic            overtemp_warn_i,
    input  wire logic            overtemp_limit_i,
    input  wire logic            low_voltage_i,
    input  wire logic            high_voltage_i,
    input  wire logic            aux_overcurrent_i,
    output logic      [LEGS-1:0] high_side_on_o,
    output logic      [LEGS-1:0] low_side_on_o,
    output logic                 switched_supply_out_o,
    output logic                 recirculation_flag_out_o,
    output logic      [2:0]      limit_select_o,
    output logic                 sense_gain_select_o,
    output logic      [1:0]      slew_select_o,
    output logic                 transmitter_enable_o,
    output logic                 stop_request_o,
    output logic                 overtemp_reset_o
);

    hbm_top_state_type q;              // Registered state
    hbm_top_state_type d;              // Next state
    logic              chop_rise;      // Synchronised rising edge pulse
    logic              chop_fall;      // Synchronised falling edge pulse
    logic [LEGS-1:0]   hs_req;         // Gated high side requests
    logic [LEGS-1:0]   ls_req;         // Gated low side requests
    logic              bridge_en;      // Global bridge permission
    logic              ot_kill;        // Enabled overtemperature shutdown
    logic              wr_drive;       // Write strobes per register
    logic              wr_ctl;
    logic              wr_sys;
    logic              wr_ifr;
    logic              wr_rmr;
    logic              wr_pout;
    logic              wr_stat;
    logic              clr_ocf;        // Overcurrent flag clear request
    logic              clr_lvf;        // Low voltage flag clear request
    logic              clr_hvf;        // High voltage flag clear request

    // Address match, shared by every strobe
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
        return addr == off;
    endfunction

    // Current limiting active for limit codes above the no-limit group
    function automatic logic limit_enabled(input logic [2:0] code);
        return code >= `HBM_LIMIT_MIN;
    endfunction

    // Chop clock edges
    hbm_chop_edge u_chop_edge (
        .clk_i           (clk_i),
        .reset_n_i       (reset_n_i),
        .chop_clock_in_i (chop_clock_in_i),
        .rise_o          (chop_rise),
        .fall_o          (chop_fall)
    );

    // Write strobes
    assign wr_drive = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_DRIVE);
    assign wr_ctl   = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_CTL);
    assign wr_sys   = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_SYS);
    assign wr_ifr   = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_IFR);
    assign wr_rmr   = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_RMR);
    assign wr_pout  = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_POUT);
    assign wr_stat  = reg_wr_en_i && reg_hit(reg_addr_i, `HBM_OFF_STAT);

    // Write-one clears; a zero bit leaves the flag alone
    assign clr_ocf = (wr_stat && reg_wdata_i[`HBM_STAT_OCF]) || (wr_ifr && reg_wdata_i[`HBM_IFR_OCF]);
    assign clr_lvf = wr_ifr && reg_wdata_i[`HBM_IFR_LVF];
    assign clr_hvf = wr_ifr && reg_wdata_i[`HBM_IFR_HVF];

    // Enabled overtemperature limit shuts every power output
    assign ot_kill   = q.htre && overtemp_limit_i;
    assign bridge_en = q.pwr_en && !q.low_voltage_flag && !q.high_voltage_flag && !ot_kill;

    // Per-leg request gating; faults override the drive bits
    generate
        for (genvar i = 0; i < LEGS; i++) begin : g_leg
            assign hs_req[i] = bridge_en && q.drive[2*i+1] && !q.hs_oc;
            assign ls_req[i] = bridge_en && q.drive[2*i] && !q.drive[2*i+1]
                               && !q.ls_oc && !q.chop_off[i];

            hbm_leg u_leg (
                .clk_i         (clk_i),
                .reset_n_i     (reset_n_i),
                .hs_req_i      (hs_req[i]),
                .ls_req_i      (ls_req[i]),
                .hs_gate_off_i (hs_gate_off_i[i]),
                .ls_gate_off_i (ls_gate_off_i[i]),
                .hs_on_o       (high_side_on_o[i]),
                .ls_on_o       (low_side_on_o[i])
            );
        end
    endgenerate

    // Next-state logic for registers, flags and output levels
    always_comb begin
        d = q;
        // Register writes
        if (wr_drive) begin
            d.drive = reg_wdata_i;
        end
        if (wr_ctl) begin
            d.ofc   = reg_wdata_i[`HBM_CTL_OFC];
            d.gain  = reg_wdata_i[`HBM_CTL_GAIN];
            d.limit = reg_wdata_i[`HBM_CTL_LIM_HI:`HBM_CTL_LIM_LO];
        end
        if (wr_sys) begin
            d.pwr_en = reg_wdata_i[`HBM_SYS_POWER_STAGE_ENABLE];
            d.slew   = reg_wdata_i[`HBM_SYS_SLEW_HI:`HBM_SYS_SLEW_LO];
        end
        d.stop = wr_sys && reg_wdata_i[`HBM_SYS_STOP];
        if (wr_rmr) begin
            d.htre = reg_wdata_i[`HBM_RMR_HTRE];
            d.hvre = reg_wdata_i[`HBM_RMR_HVRE];
        end
        if (wr_pout) begin
            d.aux_on = reg_wdata_i[`HBM_POUT_AUX];
        end
        // Sticky flags; a set in the clearing cycle wins
        if (wr_ifr && reg_wdata_i[`HBM_IFR_HTF]) begin
            d.overtemp_warning_flag = 1'b0;
        end
        if (overtemp_warn_i) begin
            d.overtemp_warning_flag = 1'b1;
        end
        if (clr_lvf) begin
            d.low_voltage_flag = 1'b0;
        end
        if (low_voltage_i) begin
            d.low_voltage_flag = 1'b1;
        end
        if (clr_hvf) begin
            d.high_voltage_flag = 1'b0;
        end
        if (high_voltage_i) begin
            d.high_voltage_flag = 1'b1;
        end
        if (clr_ocf) begin
            d.hs_oc = 1'b0;
            d.ls_oc = 1'b0;
        end
        if (hs_overcurrent_i) begin
            d.hs_oc = 1'b1;
        end
        if (ls_overcurrent_i) begin
            d.ls_oc = 1'b1;
        end
        if (wr_stat && reg_wdata_i[`HBM_STAT_AUXOC]) begin
            d.aux_oc = 1'b0;
        end
        if (aux_overcurrent_i) begin
            d.aux_oc = 1'b1;
        end
        // Current chopping: off on limit, back on at the leg's chop edge
        for (int i = 0; i < LEGS; i++) begin
            if (q.ofc && i >= 2) begin
                if (chop_fall) begin
                    d.chop_off[i] = 1'b0;
                end
            end else begin
                if (chop_rise) begin
                    d.chop_off[i] = 1'b0;
                end
            end
            if (limit_enabled(q.limit) && low_side_on_o[i] && ls_limit_hit_i[i]) begin
                d.chop_off[i] = 1'b1;
            end
        end
        if (!limit_enabled(q.limit)) begin
            d.chop_off = '0;
        end
        // Output levels
        d.supply   = q.pwr_en && q.aux_on && !q.aux_oc && !ot_kill;
        d.tx_en    = q.pwr_en;
        d.ot_reset = ot_kill;
        d.recirc   = |recirc_detect_i;
        // Register read data; unmapped addresses read zero
        if (reg_rd_en_i) begin
            unique case (reg_addr_i)
                `HBM_OFF_DRIVE: d.rdata = q.drive;
                `HBM_OFF_CTL:   d.rdata = {q.ofc, q.gain, 3'h0, q.limit};
                `HBM_OFF_SYS:   d.rdata = {q.pwr_en, q.slew, 5'h00};
                `HBM_OFF_IFR:   d.rdata = {3'h0, q.overtemp_warning_flag, q.low_voltage_flag, q.high_voltage_flag, q.hs_oc || q.ls_oc, 1'b0};
                `HBM_OFF_RMR:   d.rdata = {6'h00, q.hvre, q.htre};
                `HBM_OFF_POUT:  d.rdata = {6'h00, q.aux_on, 1'b0};
                `HBM_OFF_STAT:  d.rdata = {2'h0, q.aux_oc, 1'b0, q.low_voltage_flag, q.high_voltage_flag, q.hs_oc || q.ls_oc, q.overtemp_warning_flag};
                default:        d.rdata = `HBM_RESET_BYTE;
            endcase
        end
    end

    // State register; every control bit and flag clears at reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q       <= '0;
            q.drive <= `HBM_RESET_BYTE;
            q.limit <= `HBM_RESET_LIMIT;
            q.slew  <= `HBM_RESET_SLEW;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o              = q.rdata;
    assign switched_supply_out_o    = q.supply;
    assign recirculation_flag_out_o = q.recirc;
    assign limit_select_o           = q.limit;
    assign sense_gain_select_o      = q.gain;
    assign slew_select_o            = q.slew;
    assign transmitter_enable_o     = q.tx_en;
    assign stop_request_o           = q.stop;
    assign overtemp_reset_o         = q.ot_reset;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_bridge_off;
        (high_side_on_o == '0) && (low_side_on_o == '0);
    endsequence

    aux_supply_gate_a: assert property (!(q.aux_on && q.pwr_en) |=> !switched_supply_out_o)
        else $error("Supply on without aux on and power enable");
    power_gate_off_a: assert property (!q.pwr_en |=> s_bridge_off)
        else $error("Bridge MOSFET on while power stages disabled");
    chop_hold_off_a: assert property (q.chop_off[0] |=> !low_side_on_o[0])
        else $error("Low side on while chopped off");
    offset_fall_on_a: assert property (q.ofc && chop_fall && !(low_side_on_o[2] && ls_limit_hit_i[2])
        |=> !q.chop_off[2])
        else $error("Offset chopped leg not released on falling edge");
    recirc_follow_a: assert property (|recirc_detect_i |=> recirculation_flag_out_o)
        else $error("Recirculation flag not raised");
    overtemp_kill_a: assert property (q.htre && overtemp_limit_i |=>
        overtemp_reset_o ##0 s_bridge_off ##0 !switched_supply_out_o)
        else $error("Overtemperature limit did not shut outputs");
    hs_overcurrent_a: assert property (hs_overcurrent_i |=> q.hs_oc ##1 high_side_on_o == '0)
        else $error("High side overcurrent not handled");
    ocf_clear_a: assert property (clr_ocf && !hs_overcurrent_i && !ls_overcurrent_i |=> !q.hs_oc && !q.ls_oc)
        else $error("Overcurrent flag not cleared by write one");
    voltage_off_a: assert property (q.low_voltage_flag || q.high_voltage_flag |=> s_bridge_off)
        else $error("Bridge on during voltage fault");
    aux_overcurrent_a: assert property (aux_overcurrent_i |=> q.aux_oc ##1 !switched_supply_out_o)
        else $error("Supply overcurrent not handled");
    drive_priority_a: assert property (q.drive[1] && q.drive[0] |=> !low_side_on_o[0])
        else $error("Low side on with both drive bits set");
    supply_on_a: assert property (q.pwr_en && q.aux_on && !q.aux_oc && !ot_kill |=> switched_supply_out_o)
        else $error("Supply off although enabled");
    lvf_set_a: assert property (low_voltage_i |=> q.low_voltage_flag)
        else $error("Low voltage flag not set");
    aux_clear_a: assert property (wr_stat && reg_wdata_i[`HBM_STAT_AUXOC]
        && !aux_overcurrent_i |=> !q.aux_oc)
        else $error("Supply overcurrent flag not cleared");
endmodule

//--- hbm_map.svh
// Register offsets, field positions and reset values of the half-bridge motor control block
`ifndef HBM_MAP_SVH
`define HBM_MAP_SVH

// Register offsets on the internal serial register port
`define HBM_OFF_DRIVE     4'h1
`define HBM_OFF_CTL       4'h2
`define HBM_OFF_SYS       4'h3
`define HBM_OFF_IFR       4'h5
`define HBM_OFF_RMR       4'h6
`define HBM_OFF_POUT      4'hb
`define HBM_OFF_STAT      4'hc

// Bridge control fields
`define HBM_CTL_OFC       7
`define HBM_CTL_GAIN      6
`define HBM_CTL_LIM_HI    2
`define HBM_CTL_LIM_LO    0

// System control fields
`define HBM_SYS_POWER_STAGE_ENABLE      7
`define HBM_SYS_SLEW_HI   6
`define HBM_SYS_SLEW_LO   5
`define HBM_SYS_STOP      0

// Power output, reset mask fields
`define HBM_POUT_AUX      1
`define HBM_RMR_HVRE      1
`define HBM_RMR_HTRE      0

// Interrupt flag fields
`define HBM_IFR_HTF       4
`define HBM_IFR_LVF       3
`define HBM_IFR_HVF       2
`define HBM_IFR_OCF       1

// System status fields
`define HBM_STAT_AUXOC    5
`define HBM_STAT_LVF      3
`define HBM_STAT_HVF      2
`define HBM_STAT_OCF      1
`define HBM_STAT_HTF      0

// Reset values and limit decode
`define HBM_RESET_BYTE    8'h00
`define HBM_RESET_LIMIT   3'h0
`define HBM_RESET_SLEW    2'h0
`define HBM_LIMIT_MIN     3'h3

`endif

//--- hbm_pkg.sv
// Types shared by the half-bridge motor control modules
package hbm_pkg;

    typedef logic [7:0] hbm_byte_type;

    // Chop clock synchroniser and edge detector state
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic rise;
        logic fall;
    } hbm_edge_state_type;

    // One half-bridge leg state
    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } hbm_leg_state_type;

    // Register file and protection state
    typedef struct packed {
        hbm_byte_type drive;
        logic         ofc;
        logic         gain;
        logic [2:0]   limit;
        logic         pwr_en;
        logic [1:0]   slew;
        logic         aux_on;
        logic         htre;
        logic         hvre;
        logic         overtemp_warning_flag;
        logic         low_voltage_flag;
        logic         high_voltage_flag;
        logic         hs_oc;
        logic         ls_oc;
        logic         aux_oc;
        logic [3:0]   chop_off;
        logic         stop;
        logic         ot_reset;
        logic         supply;
        logic         recirc;
        logic         tx_en;
        hbm_byte_type rdata;
    } hbm_top_state_type;

endpackage

//--- hbm_chop_edge.sv
// Chop clock synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module hbm_chop_edge
    import hbm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic chop_clock_in_i,
    output logic      rise_o,
    output logic      fall_o
);

    hbm_edge_state_type q;   // Registered state
    hbm_edge_state_type d;   // Next state

    // Two-stage synchroniser; edges are taken from the second stage only
    always_comb begin
        d      = q;
        d.s1   = chop_clock_in_i;
        d.s2   = q.s1;
        d.prev = q.s2;
        d.rise = q.s2 && !q.prev;
        d.fall = !q.s2 && q.prev;
    end

    // State register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise_o = q.rise;
    assign fall_o = q.fall;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    edge_one_cycle_a: assert property ((rise_o || fall_o) |=> !(rise_o || fall_o))
        else $error("Chop edge pulse longer than one cycle");
endmodule

//--- hbm_leg.sv
// One half-bridge leg with high side priority and break-before-make
`timescale 1ns/10ps
module hbm_leg
    import hbm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic hs_req_i,
    input  wire logic ls_req_i,
    input  wire logic hs_gate_off_i,
    input  wire logic ls_gate_off_i,
    output logic      hs_on_o,
    output logic      ls_on_o
);

    hbm_leg_state_type q;   // Registered gate commands
    hbm_leg_state_type d;   // Next gate commands

    // A side turns on only once the opposite gate is commanded and seen off
    always_comb begin
        d       = q;
        d.hs_on = hs_req_i && !q.ls_on && ls_gate_off_i;
        d.ls_on = ls_req_i && !hs_req_i && !q.hs_on && hs_gate_off_i;
    end

    // Gate command register, off after reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign hs_on_o = q.hs_on;
    assign ls_on_o = q.ls_on;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    no_shoot_through_a: assert property (!(hs_on_o && ls_on_o))
        else $error("Both MOSFETs of one leg on");
    bbm_high_side_a: assert property ($rose(hs_on_o) |-> $past(ls_gate_off_i) && !$past(ls_on_o))
        else $error("High side on before low side confirmed off");
    bbm_low_side_a: assert property ($rose(ls_on_o) |-> $past(hs_gate_off_i) && !$past(hs_on_o))
        else $error("Low side on before high side confirmed off");
    high_priority_a: assert property (hs_req_i && ls_req_i |=> !ls_on_o)
        else $error("Low side on while high side requested");
endmodule

//--- hbm_load_model.sv
// Winding load model: reports each gate as off some cycles after its command drops
`timescale 1ns/10ps
module hbm_load_model #(
    parameter int DELAY = 3
)(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [3:0] hs_on_i,
    input  wire logic [3:0] ls_on_i,
    output logic      [3:0] hs_gate_off_o,
    output logic      [3:0] ls_gate_off_o
);
    int hc[4]; // Cycles since high side command dropped
    int lc[4]; // Cycles since low side command dropped
    // Gate discharge takes DELAY cycles, so the opposite side must wait
    always @(posedge clk_i or negedge reset_n_i) begin
        for (int i = 0; i < 4; i++) begin
            if (!reset_n_i) begin
                hc[i] <= DELAY;
                lc[i] <= DELAY;
            end else begin
                hc[i] <= hs_on_i[i] ? 0 : (hc[i] < DELAY ? hc[i] + 1 : DELAY);
                lc[i] <= ls_on_i[i] ? 0 : (lc[i] < DELAY ? lc[i] + 1 : DELAY);
            end
        end
    end
    // Off confirmation only once the count has run out
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hs_gate_off_o[i] = hc[i] >= DELAY;
            ls_gate_off_o[i] = lc[i] >= DELAY;
        end
    end
endmodule

//--- hbm_top_tb.sv
// Self-checking testbench of the half-bridge motor control block
`timescale 1ns/10ps
module hbm_top_tb;
    import hbm_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr  = 4'h0;
    logic       we    = 1'b0;
    logic       re    = 1'b0;
    logic [7:0] wd    = 8'h00;
    logic [7:0] rdata;
    logic       chop  = 1'b0; // Chop clock stepped by hand in t_chop: one rise, then one fall
    logic [3:0] hit   = 4'h0;
    logic       hoc   = 1'b0;
    logic       loc   = 1'b0;
    logic [3:0] rec   = 4'h0;
    logic       otw   = 1'b0;
    logic       otl   = 1'b0;
    logic       lv    = 1'b0;
    logic       hv    = 1'b0;
    logic       aoc   = 1'b0;
    logic [3:0] hs, ls, hgo, lgo;
    logic       sup, recirculation_flag_out, gain, txe, stp, otr;
    logic [2:0] lim;
    logic [1:0] slew;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    always #20 clk_i = ~clk_i;
    hbm_top hbm_top_i (.clk_i(clk_i), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wr_en_i(we),
        .reg_rd_en_i(re), .reg_wdata_i(wd), .reg_rdata_o(rdata), .chop_clock_in_i(chop),
        .ls_limit_hit_i(hit), .hs_overcurrent_i(hoc), .ls_overcurrent_i(loc), .hs_gate_off_i(hgo),
        .ls_gate_off_i(lgo), .recirc_detect_i(rec), .overtemp_warn_i(otw), .overtemp_limit_i(otl),
        .low_voltage_i(lv), .high_voltage_i(hv), .aux_overcurrent_i(aoc), .high_side_on_o(hs),
        .low_side_on_o(ls), .switched_supply_out_o(sup), .recirculation_flag_out_o(recirculation_flag_out),
        .limit_select_o(lim), .sense_gain_select_o(gain), .slew_select_o(slew),
        .transmitter_enable_o(txe), .stop_request_o(stp), .overtemp_reset_o(otr));
    hbm_load_model hbm_load_model_i (.clk_i(clk_i), .reset_n_i(rst_n), .hs_on_i(hs),
        .ls_on_i(ls), .hs_gate_off_o(hgo), .ls_gate_off_o(lgo));
    // Wait a number of cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        wd   <= v;
        we   <= 1'b1;
        @(posedge clk_i);
        we   <= 1'b0;
    endtask
    // Read and compare one register
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk_i);
        re   <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Compare and count
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Reset values and register layout
    task automatic t_regs();
        chk({hs, ls}, 8'h00);
        chk({7'h00, sup}, 8'h00);
        rc(4'h1, 8'h00);
        wr(4'h2, 8'hff);
        rc(4'h2, 8'hc7);
        #1 chk({4'h0, gain, lim}, 8'h0f);
        wr(4'h3, 8'h7f);
        #1 chk({7'h00, stp}, 8'h01);
        rc(4'h3, 8'h60);
        chk({6'h00, slew}, 8'h03);
        chk({7'h00, stp}, 8'h00);
        wr(4'h2, 8'h00);
        rc(4'h2, 8'h00);
        $display("test regs done");
    endtask
    // Enable gating, high side priority, break-before-make
    task automatic t_drive();
        wr(4'h1, 8'h01);
        cyc(6);
        chk({hs, ls}, 8'h00);
        wr(4'h3, 8'h80);
        wr(4'h1, 8'h03);
        cyc(6);
        chk({hs, ls}, 8'h10);
        wr(4'h1, 8'h01);
        cyc(2);
        chk({hs, ls}, 8'h00);
        cyc(6);
        chk({hs, ls}, 8'h01);
        chk({7'h00, txe}, 8'h01);
        $display("test drive done");
    endtask
    // Current chopping with offset release
    task automatic t_chop();
        wr(4'h2, 8'h83);
        wr(4'h1, 8'h11);
        cyc(6);
        hit <= 4'h5;
        cyc(3);
        hit <= 4'h0;
        cyc(4);
        chk({4'h0, ls}, 8'h00);
        chop <= 1'b1;
        cyc(6);
        chk({4'h0, ls}, 8'h01);
        chop <= 1'b0;
        cyc(6);
        chk({4'h0, ls}, 8'h05);
        $display("test chop done");
    endtask
    // Overcurrent, low voltage flag, recirculation
    task automatic t_faults();
        loc <= 1'b1;
        cyc(3);
        loc <= 1'b0;
        chk({4'h0, ls}, 8'h00);
        wr(4'hc, 8'h00);
        rc(4'hc, 8'h02);
        wr(4'hc, 8'h02);
        cyc(6);
        chk({4'h0, ls}, 8'h05);
        lv <= 1'b1;
        cyc(3);
        lv <= 1'b0;
        chk({4'h0, ls}, 8'h00);
        wr(4'h5, 8'h08);
        cyc(6);
        chk({4'h0, ls}, 8'h05);
        rec <= 4'h8;
        cyc(2);
        chk({7'h00, recirculation_flag_out}, 8'h01);
        rec <= 4'h0;
        cyc(2);
        chk({7'h00, recirculation_flag_out}, 8'h00);
        $display("test faults done");
    endtask
    // Switched supply control and protection
    task automatic t_supply();
        wr(4'hb, 8'h02);
        cyc(2);
        chk({7'h00, sup}, 8'h01);
        aoc <= 1'b1;
        cyc(2);
        aoc <= 1'b0;
        rc(4'hc, 8'h20);
        chk({7'h00, sup}, 8'h00);
        wr(4'hc, 8'h20);
        cyc(2);
        chk({7'h00, sup}, 8'h01);
        otl <= 1'b1;
        cyc(2);
        chk({6'h00, sup, otr}, 8'h02);
        wr(4'h6, 8'h01);
        cyc(2);
        chk({6'h00, sup, otr}, 8'h01);
        otl <= 1'b0;
        wr(4'h3, 8'h00);
        cyc(2);
        chk({3'h0, sup, ls}, 8'h00);
        $display("test supply done");
    endtask
    // Temperature warning, persistent voltage fault, high side overcurrent
    task automatic t_flags();
        otw <= 1'b1;
        cyc(2);
        otw <= 1'b0;
        rc(4'h5, 8'h10);
        rc(4'hc, 8'h01);
        wr(4'h5, 8'h10);
        rc(4'h5, 8'h00);
        cyc(1);
        hv <= 1'b1;
        wr(4'h5, 8'h04);
        rc(4'h5, 8'h04);
        chk({4'h0, ls}, 8'h00);
        cyc(1);
        hv <= 1'b0;
        wr(4'h5, 8'h04);
        rc(4'h5, 8'h00);
        wr(4'h1, 8'h12);
        cyc(8);
        chk({hs, ls}, 8'h14);
        hoc <= 1'b1;
        cyc(3);
        hoc <= 1'b0;
        chk({hs, ls}, 8'h04);
        wr(4'hc, 8'h02);
        cyc(4);
        chk({hs, ls}, 8'h14);
        $display("test flags done");
    endtask
    // Mid-run reset clears drive, supply bit and overcurrent flag
    task automatic t_reset();
        loc <= 1'b1;
        cyc(2);
        loc <= 1'b0;
        rc(4'hc, 8'h02);
        cyc(1);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rc(4'hc, 8'h00);
        rc(4'h1, 8'h00);
        rc(4'hb, 8'h00);
        chk({hs, ls}, 8'h00);
        chk({7'h00, sup}, 8'h00);
        $display("test reset done");
    endtask
    // Counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(1);
        t_regs();
        t_drive();
        t_chop();
        t_faults();
        t_flags();
        t_supply();
        t_reset();
        summarize();
    end
    // Hang guard
    initial begin
        cyc(3000);
        n_mismatch++;
        summarize();
    end
endmodule
